// file: dic_pkg.sv
package dic_pkg;

  // Widths
  localparam int FILT_W = 16;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [31:0] OFF_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFF_FILTER = 32'h0000_0004;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0008;
  localparam logic [31:0] OFF_EVENT  = 32'h0000_000C;

  // Control register fields
  localparam int CTL_INVERT   = 0;
  localparam int CTL_OVERRIDE = 1;
  localparam int CTL_LASTGOOD = 2;
  localparam int CTL_ALARM    = 3;
  localparam int CTL_OVR_VAL  = 4;
  localparam int CTL_FLT_VAL  = 5;
  localparam int CTL_CURRENT  = 6;

  // Status register fields
  localparam int STA_LIVE     = 0;
  localparam int STA_SELECTED = 1;
  localparam int STA_LASTGOOD = 2;
  localparam int STA_FAULT    = 3;
  localparam int STA_SOURCE   = 4;
  localparam int STA_RAW      = 6;

  // Event register fields, write one to clear
  localparam int EVT_SET = 0;
  localparam int EVT_CLR = 1;

  // Reset values
  localparam logic [FILT_W-1:0] FILTER_RST = 16'h0000;
  localparam logic [31:0]       WORD_ZERO  = 32'h0000_0000;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic {DIC_OP_LIVE, DIC_OP_OVERRIDE} dic_op_t;
  typedef enum logic {DIC_FM_VALUE, DIC_FM_LASTGOOD} dic_fm_t;
  typedef enum logic {DIC_CUR_66UA, DIC_CUR_2MA} dic_cur_t;
  typedef enum logic [1:0] {
    DIC_SRC_LIVE,
    DIC_SRC_OVERRIDE,
    DIC_SRC_FAULT,
    DIC_SRC_LASTGOOD
  } dic_src_t;

endpackage

// file: dic_filter.sv
`timescale 1ns/1ps
module dic_filter #(
  parameter int FILT_W = dic_pkg::FILT_W
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Conditioned input and timing
  input  wire logic              rawIn,
  input  wire logic              tick,
  input  wire logic [FILT_W-1:0] filterTime,
  // Filtered state
  output logic                   filtered
);
  import dic_pkg::*;

  typedef struct packed {
    logic [FILT_W-1:0] count;
    logic              on;
  } dic_filt_t;

  dic_filt_t s_q;
  dic_filt_t s_d;

  // Count stops at the programmed time, so it never wraps back to Off
  always_comb begin
    s_d = s_q;
    if (!rawIn) begin
      s_d.count = '0;
      s_d.on    = 1'b0;
    end else begin
      if (tick && (s_q.count < filterTime)) begin
        s_d.count = s_q.count + 1'b1;
      end
      s_d.on = (s_d.count >= filterTime);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.count <= FILT_W'(FILTER_RST);
      s_q.on    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign filtered = s_q.on;

endmodule

// file: dic_top.sv
`timescale 1ns/1ps
// What this block does
// - A control bit picks 66 microamp or 2 milliamp source current for the front end.
// - With inversion on, the selected value is the complement of the live state.
// - With inversion off, the live state passes unchanged to the selected value.
// - Inversion acts only in live mode with no fault present.
// - Input reads On only after staying high for the programmed whole seconds.
// - Filtered input drops to Off at once when the raw input goes low.
// - Live mode copies the filtered, possibly inverted, live state to the selected value.
// - Override mode copies the override value and ignores the live state.
// - Override mode keeps the override value even while a fault is present.
// - Fault outside override with fault-value option selects the configured fault value.
// - Fault outside override with last-good option selects the stored last good value.
// - Alarm mode Off raises no set or clear alarm events.
// - Alarm mode On raises set-alarm on each off-to-on selected transition.
// - Alarm mode On raises clear-alarm on each on-to-off transition.
// - Live input state is readable status that writes cannot change.
// - A one-bit override value sets the channel state in override mode.
// - A one-bit fault value applies on fault with the fault-value option.
// - The most recent good state is recorded as read-only for last-good use.
module dic_top #(
  parameter int FILT_W = dic_pkg::FILT_W
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Field input and front end
  input  wire logic        rawIn,
  input  wire logic        channelFault,
  input  wire logic        oneSecTick,
  output logic             sourceHigh,
  // Downstream
  output logic             selectedValue,
  output logic             setAlarm,
  output logic             clearAlarm,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import dic_pkg::*;

  typedef struct packed {
    // Synchronisers
    logic              rawMeta;
    logic              rawSync;
    logic              faultMeta;
    logic              faultSync;
    // Configuration
    logic              invert;
    dic_op_t           opMode;
    dic_fm_t           faultMode;
    logic              alarmOn;
    logic              overrideVal;
    logic              faultVal;
    dic_cur_t          current;
    logic [FILT_W-1:0] filterTime;
    // Channel state
    logic              lastGood;
    logic              selected;
    dic_src_t          source;
    logic              setPulse;
    logic              clrPulse;
    logic              setSticky;
    logic              clrSticky;
    // Bus data phase
    logic              dataPhase;
    logic              dataWrite;
    logic [31:0]       dataAddr;
    logic [31:0]       rdata;
    logic              readyOut;
    logic              respOut;
  } dic_state_t;

  dic_state_t s_q;
  dic_state_t s_d;

  logic liveState;
  logic liveSel;
  logic selNext;
  logic accept;

  // Filter sees only the synchronised copy of the pin
  dic_filter #(
    .FILT_W     (FILT_W)
  ) u_filter (
    .clock      (clock),
    .reset      (reset),
    .rawIn      (s_q.rawSync),
    .tick       (oneSecTick),
    .filterTime (s_q.filterTime),
    .filtered   (liveState)
  );

  function automatic logic [31:0] dicReadWord(
    input logic [31:0] addr,
    input dic_state_t  s,
    input logic        live
  );
    logic [31:0] w;
    w = WORD_ZERO;
    case (addr)
      OFF_CTRL: begin
        w[CTL_INVERT]   = s.invert;
        w[CTL_OVERRIDE] = (s.opMode == DIC_OP_OVERRIDE);
        w[CTL_LASTGOOD] = (s.faultMode == DIC_FM_LASTGOOD);
        w[CTL_ALARM]    = s.alarmOn;
        w[CTL_OVR_VAL]  = s.overrideVal;
        w[CTL_FLT_VAL]  = s.faultVal;
        w[CTL_CURRENT]  = (s.current == DIC_CUR_2MA);
      end
      OFF_FILTER: begin
        w[FILT_W-1:0] = s.filterTime;
      end
      OFF_STATUS: begin
        w[STA_LIVE]                  = live;
        w[STA_SELECTED]              = s.selected;
        w[STA_LASTGOOD]              = s.lastGood;
        w[STA_FAULT]                 = s.faultSync;
        w[STA_SOURCE+1:STA_SOURCE]   = s.source;
        w[STA_RAW]                   = s.rawSync;
      end
      OFF_EVENT: begin
        w[EVT_SET] = s.setSticky;
        w[EVT_CLR] = s.clrSticky;
      end
      default: begin
        w = WORD_ZERO;
      end
    endcase
    return w;
  endfunction

  // Only whole-word single transfers are expected; hsize is not checked
  assign accept = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));

  always_comb begin
    s_d = s_q;

    // Two flops before any logic reads the pins
    s_d.rawMeta   = rawIn;
    s_d.rawSync   = s_q.rawMeta;
    s_d.faultMeta = channelFault;
    s_d.faultSync = s_q.faultMeta;

    // Inversion of the live state
    if (s_q.invert) begin
      liveSel = ~liveState;
    end else begin
      liveSel = liveState;
    end

    // Source selection, override has top priority
    if (s_q.opMode == DIC_OP_OVERRIDE) begin
      selNext     = s_q.overrideVal;
      s_d.source  = DIC_SRC_OVERRIDE;
    end else if (s_q.faultSync) begin
      if (s_q.faultMode == DIC_FM_VALUE) begin
        selNext    = s_q.faultVal;
        s_d.source = DIC_SRC_FAULT;
      end else begin
        selNext    = s_q.lastGood;
        s_d.source = DIC_SRC_LASTGOOD;
      end
    end else begin
      selNext     = liveSel;
      s_d.source  = DIC_SRC_LIVE;
    end
    s_d.selected = selNext;

    // Last good tracks the uninverted live state while healthy
    if (!s_q.faultSync) begin
      s_d.lastGood = liveState;
    end

    // Alarm events on edges of the selected value
    s_d.setPulse = s_q.alarmOn && selNext && !s_q.selected;
    s_d.clrPulse = s_q.alarmOn && !selNext && s_q.selected;

    // Sticky copies; a new event wins over a clear in the same cycle
    s_d.setSticky = s_q.setSticky;
    s_d.clrSticky = s_q.clrSticky;

    // Bus data phase: writes land here
    s_d.readyOut = 1'b1;
    s_d.respOut  = HRESP_OKAY;
    if (s_q.dataPhase && s_q.dataWrite) begin
      case (s_q.dataAddr)
        OFF_CTRL: begin
          s_d.invert      = hwdata[CTL_INVERT];
          s_d.opMode      = dic_op_t'(hwdata[CTL_OVERRIDE]);
          s_d.faultMode   = dic_fm_t'(hwdata[CTL_LASTGOOD]);
          s_d.alarmOn     = hwdata[CTL_ALARM];
          s_d.overrideVal = hwdata[CTL_OVR_VAL];
          s_d.faultVal    = hwdata[CTL_FLT_VAL];
          s_d.current     = dic_cur_t'(hwdata[CTL_CURRENT]);
        end
        OFF_FILTER: begin
          s_d.filterTime = hwdata[FILT_W-1:0];
        end
        OFF_EVENT: begin
          if (hwdata[EVT_SET]) begin
            s_d.setSticky = 1'b0;
          end
          if (hwdata[EVT_CLR]) begin
            s_d.clrSticky = 1'b0;
          end
        end
        default: begin
          s_d.dataAddr = s_q.dataAddr;
        end
      endcase
    end

    // Alarm off means no events at all
    if (!s_q.alarmOn) begin
      s_d.setPulse = 1'b0;
      s_d.clrPulse = 1'b0;
    end
    if (s_d.setPulse) begin
      s_d.setSticky = 1'b1;
    end
    if (s_d.clrPulse) begin
      s_d.clrSticky = 1'b1;
    end

    // Address phase: read data is sampled now, so the data phase needs no wait
    s_d.dataPhase = accept;
    s_d.dataWrite = accept && hwrite;
    if (accept) begin
      s_d.dataAddr = haddr;
    end
    if (accept && !hwrite) begin
      s_d.rdata = dicReadWord(haddr, s_q, liveState);
    end else begin
      s_d.rdata = WORD_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.rawMeta     <= 1'b0;
      s_q.rawSync     <= 1'b0;
      s_q.faultMeta   <= 1'b0;
      s_q.faultSync   <= 1'b0;
      s_q.invert      <= 1'b0;
      s_q.opMode      <= DIC_OP_LIVE;
      s_q.faultMode   <= DIC_FM_VALUE;
      s_q.alarmOn     <= 1'b0;
      s_q.overrideVal <= 1'b0;
      s_q.faultVal    <= 1'b0;
      s_q.current     <= DIC_CUR_66UA;
      s_q.filterTime  <= FILT_W'(FILTER_RST);
      s_q.lastGood    <= 1'b0;
      s_q.selected    <= 1'b0;
      s_q.source      <= DIC_SRC_LIVE;
      s_q.setPulse    <= 1'b0;
      s_q.clrPulse    <= 1'b0;
      s_q.setSticky   <= 1'b0;
      s_q.clrSticky   <= 1'b0;
      s_q.dataPhase   <= 1'b0;
      s_q.dataWrite   <= 1'b0;
      s_q.dataAddr    <= WORD_ZERO;
      s_q.rdata       <= WORD_ZERO;
      s_q.readyOut    <= 1'b1;
      s_q.respOut     <= HRESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from a state flop
  assign sourceHigh    = logic'(s_q.current);
  assign selectedValue = s_q.selected;
  assign setAlarm      = s_q.setPulse;
  assign clearAlarm    = s_q.clrPulse;
  assign hreadyout     = s_q.readyOut;
  assign hrdata        = s_q.rdata;
  assign hresp         = s_q.respOut;

endmodule

// file: dic_top_sva.sv
`timescale 1ns/1ps
module dic_top_sva import dic_pkg::*; #(
  parameter int FILT_W = 16
) (
  // Clock, reset and field side
  input wire logic        clock, reset, rawIn, channelFault, oneSecTick,
  input wire logic        sourceHigh, selectedValue, setAlarm, clearAlarm,
  // Bus
  input wire logic        hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize
);
  logic [31:0] ctl_q;
  logic        wrCtl_q;
  // Shadow of the control word, snooped off the bus so mode is known here
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_q <= WORD_ZERO;
      wrCtl_q <= 1'b0;
    end else begin
      wrCtl_q <= hsel && hready && htrans[1] && hwrite && haddr == OFF_CTRL;
      if (wrCtl_q) ctl_q <= hwdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Six cycles cover the two sync flops, the filter and the select stage
  sequence liveLow;
    (!ctl_q[CTL_OVERRIDE] && !ctl_q[CTL_INVERT] && !channelFault && !rawIn
      && $stable(ctl_q)) [*6];
  endsequence
  sequence faultHeld;
    (!ctl_q[CTL_OVERRIDE] && !ctl_q[CTL_LASTGOOD] && channelFault && $stable(ctl_q)) [*5];
  endsequence
  a_bus_ready: assert property (hreadyout) else $error("bus stalled");
  a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bad response");
  a_source_map: assert property (sourceHigh == ctl_q[CTL_CURRENT])
    else $error("source current select wrong");
  a_set_single: assert property (setAlarm |=> !setAlarm)
    else $error("set pulse too long");
  a_set_cause: assert property (setAlarm |-> $rose(selectedValue))
    else $error("set without rise");
  a_clear_cause: assert property (clearAlarm |-> $fell(selectedValue))
    else $error("clear without fall");
  a_quiet_off: assert property (!$past(ctl_q[CTL_ALARM]) |-> !setAlarm && !clearAlarm)
    else $error("event with alarm off");
  a_rise_sets: assert property ($rose(selectedValue) && $past(ctl_q[CTL_ALARM]) |-> setAlarm)
    else $error("rise without set");
  a_fall_clears: assert property ($fell(selectedValue) && $past(ctl_q[CTL_ALARM]) |-> clearAlarm)
    else $error("fall without clear");
  a_override_hold: assert property (ctl_q[CTL_OVERRIDE] && $stable(ctl_q)
    |-> selectedValue == ctl_q[CTL_OVR_VAL]) else $error("override value lost");
  a_fall_fast: assert property (liveLow |-> !selectedValue)
    else $error("off not immediate");
  a_fault_value: assert property (faultHeld |-> selectedValue == ctl_q[CTL_FLT_VAL])
    else $error("fault value not applied");
endmodule

// file: dic_sensor.sv
`timescale 1ns/1ps
// Contact that follows its command after a chosen lag, to mimic slow switches
module dic_sensor (
  input  wire logic       clock,
  input  wire logic       closeCmd,
  input  wire logic [2:0] lag,
  output logic            rawIn
);
  logic [7:0] hist_q = 8'h00;
  always_ff @(posedge clock) hist_q <= {hist_q[6:0], closeCmd};
  assign rawIn = hist_q[lag];
endmodule

// file: tb_dic_top.sv
`timescale 1ns/1ps
module tb_dic_top;
  import dic_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, closeCmd = 1'b0, channelFault = 1'b0;
  logic        oneSecTick = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [2:0]  lag = 3'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, hrdata;
  logic        rawIn, sourceHigh, selectedValue, setAlarm, clearAlarm, hreadyout, hresp;
  logic [31:0] regs [4] = '{OFF_CTRL, OFF_FILTER, OFF_STATUS, OFF_EVENT};
  int          failures = 0, checked = 0;
  dic_sensor u_sensor (.clock(clock), .closeCmd(closeCmd), .lag(lag), .rawIn(rawIn));
  dic_top #(.FILT_W(16)) u_dut (.clock(clock), .reset(reset), .rawIn(rawIn),
    .channelFault(channelFault), .oneSecTick(oneSecTick), .sourceHigh(sourceHigh),
    .selectedValue(selectedValue), .setAlarm(setAlarm), .clearAlarm(clearAlarm),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  initial forever #50 clock = ~clock;
  task automatic end_of_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Bounded wait for hready; the bus never promises a cycle count
  // Ready and read data are taken where settled, so the edge that ends the phase cannot race
  task automatic waitRdy(output logic [31:0] r);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    r = WORD_ZERO;
    do begin
      @(negedge clock);
      rdy = hreadyout;
      r = hrdata;
      @(posedge clock);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    waitRdy(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy(r);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdChk(input logic [31:0] a, exp, input string msg);
    logic [31:0] r;
    xfer(1'b0, a, WORD_ZERO, r);
    chk(r, exp, msg);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      oneSecTick <= 1'b1;
      @(posedge clock);
      oneSecTick <= 1'b0;
      wt(3);
    end
  endtask
  task automatic selChk(input logic exp, input string msg);
    wt(8);
    chk(32'(selectedValue), 32'(exp), msg);
  endtask
  initial begin
    wt(4);
    reset <= 1'b0;
    foreach (regs[i]) rdChk(regs[i], WORD_ZERO, "reset value");
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rdChk(OFF_STATUS, WORD_ZERO, "status written");
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    rdChk(32'h0000_0010, WORD_ZERO, "unmapped read");
    wr(OFF_CTRL, 32'hFFFF_FFFF);
    rdChk(OFF_CTRL, 32'h0000_007F, "control fields");
    chk(32'(sourceHigh), 32'h0000_0001, "2 mA select");
    wr(OFF_FILTER, 32'hFFFF_FFFF);
    rdChk(OFF_FILTER, 32'h0000_FFFF, "filter field");
    wr(OFF_CTRL, 32'h0000_0008);
    wr(OFF_FILTER, 32'h0000_0003);
    // Drop events left by the mode changes above, so only the field input can set them
    wr(OFF_EVENT, 32'h0000_0003);
    chk(32'(sourceHigh), 32'h0000_0000, "66 uA select");
    lag <= 3'h3;
    closeCmd <= 1'b1;
    wt(12);
    tick(2);
    selChk(1'b0, "on before filter time");
    tick(1);
    selChk(1'b1, "not on at filter time");
    rdChk(OFF_STATUS, 32'h0000_0047, "status live");
    lag <= 3'h0;
    closeCmd <= 1'b0;
    selChk(1'b0, "off delayed");
    closeCmd <= 1'b1;
    wt(10);
    tick(2);
    closeCmd <= 1'b0;
    wt(6);
    closeCmd <= 1'b1;
    wt(10);
    tick(2);
    selChk(1'b0, "count not restarted");
    tick(1);
    selChk(1'b1, "not on after restart");
    rdChk(OFF_EVENT, 32'h0000_0003, "events missing");
    wr(OFF_EVENT, 32'h0000_0003);
    rdChk(OFF_EVENT, WORD_ZERO, "events not cleared");
    wr(OFF_CTRL, WORD_ZERO);
    closeCmd <= 1'b0;
    selChk(1'b0, "live off");
    rdChk(OFF_EVENT, WORD_ZERO, "event with alarm off");
    wr(OFF_FILTER, WORD_ZERO);
    wr(OFF_CTRL, 32'h0000_0001);
    selChk(1'b1, "inverted off");
    closeCmd <= 1'b1;
    selChk(1'b0, "inverted on");
    wr(OFF_CTRL, WORD_ZERO);
    selChk(1'b1, "plain on");
    // Fault and inversion set too: neither may leak through override
    for (int v = 0; v < 4; v++) begin
      channelFault <= v[1];
      wr(OFF_CTRL, 32'h0000_0023 | (32'h0000_0010 & {32{v[0]}}));
      selChk(v[0], "override value");
    end
    for (int f = 0; f < 2; f++) begin
      wr(OFF_CTRL, 32'h0000_0001 | (32'h0000_0020 & {32{f[0]}}));
      selChk(f[0], "fault value");
    end
    channelFault <= 1'b0;
    wr(OFF_CTRL, 32'h0000_0005);
    selChk(1'b0, "inverted before fault");
    channelFault <= 1'b1;
    closeCmd <= 1'b0;
    selChk(1'b1, "last good");
    rdChk(OFF_STATUS, 32'h0000_003E, "status last good");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test();
  end
endmodule
bind dic_top dic_top_sva #(.FILT_W(FILT_W)) u_sva (.clock(clock), .reset(reset),
  .rawIn(rawIn), .channelFault(channelFault), .oneSecTick(oneSecTick),
  .sourceHigh(sourceHigh), .selectedValue(selectedValue), .setAlarm(setAlarm),
  .clearAlarm(clearAlarm), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hwdata(hwdata),
  .hrdata(hrdata), .htrans(htrans), .hsize(hsize));
